// ==== fcs_cpu.sv ====
// processor core model issuing register and array writes
`default_nettype none
module fcs_cpu (
  input wire logic mclk,
  input wire logic [7:0] regRdData,
  output logic [1:0] regAddr,
  output logic [7:0] regWrData,
  output logic regWrite,
  output logic regRead,
  output logic arrayWrite,
  output logic [15:0] arrayAddr,
  output logic [7:0] arrayData
);
  timeunit 1ns;
  timeprecision 100ps;
  import fcs_pkg::*;
  initial begin
    {regWrite, regRead, arrayWrite} = 3'h0;
    {regAddr, regWrData, arrayAddr, arrayData} = '0;
  end
  // one strobe cycle; released data flips so it never looks valid
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge mclk);
    regAddr <= a;
    regWrData <= v;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
    regWrData <= ~v;
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge mclk);
    regRead <= 1'b0;
    #1 d = regRdData;
  endtask
  // first step of any command
  task automatic arr(input logic [15:0] a, input logic [7:0] v);
    @(posedge mclk);
    arrayAddr <= a;
    arrayData <= v;
    arrayWrite <= 1'b1;
    @(posedge mclk);
    arrayWrite <= 1'b0;
    arrayData <= ~v;
  endtask
  // array, code, launch with a one in the empty flag
  task automatic cmd(input logic [15:0] a, input logic [7:0] v, input logic [7:0] c);
    arr(a, v);
    wr(REG_CMD, c);
    wr(REG_STAT, 8'h80);
  endtask
endmodule
`default_nettype wire

// ==== fcs_flash_command_sequencer.sv ====
// flash command sequencer: divider, command protocol and pulse timing
// Functional notes
// - only first divider write after reset
// - divider write blocked while access error
// - operations timed in whole flash periods
// - byte program 9, burst byte 4
// - page erase 4000, mass erase 20000
// - sequence starts with latched array write
// - erase ignores data, page by address
// - erase unit is a 512-byte page
// - blank check 05, erases 40, 41
// - programs 20 and 25, code buffered
// - writing one to empty flag launches
// - writing zero mid-sequence aborts with error
// - error must clear before new sequence
// - out-of-order sequence refused
// - complete flag shows command finished
// - access error cleared by writing one
// - invalid command code sets access error
// - array write while buffer full errors
// - stop during operation aborts with error
//
// The strobed register port and the register offsets were decided locally.
`default_nettype none
module fcs_flash_command_sequencer #(
  parameter int MASS_ERASE_TICKS = fcs_pkg::MASS_TICKS_DEFAULT
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [fcs_pkg::ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  input wire logic arrayWrite,
  input wire logic [fcs_pkg::ARR_ADDR_W-1:0] arrayAddr,
  input wire logic [7:0] arrayData,
  input wire logic stopReq,
  input wire logic arrayBlank,
  output logic pumpOn,
  output logic programActive,
  output logic eraseActive,
  output logic massErase,
  output logic [fcs_pkg::ARR_ADDR_W-1:0] opAddr,
  output logic [7:0] opData,
  output logic flashTick
);
  import fcs_pkg::*;

  fcs_seq_type seq_q, seq_d;
  logic divLoaded_q;
  logic pre8_q;
  logic [DIV_W-1:0] div_q;
  logic [2:0] preCnt_q;
  logic [DIV_W-1:0] divCnt_q;
  logic accerr_q;
  logic ccf_q;
  logic blank_q;
  logic [7:0] cmdBuf_q;
  logic [ARR_ADDR_W-1:0] latAddr_q;
  logic [7:0] latData_q;
  logic busy_q;
  logic [7:0] opCmd_q;
  logic [TICK_W-1:0] tickCnt_q;
  logic wrDiv, wrStat, wrCmd;
  logic accSet, accClr, launch, take, execDone, chain, stopAbort, validCmd;
  logic preWrap;

  // register port decode
  assign wrDiv = regWrite && (regAddr == REG_DIV);
  assign wrStat = regWrite && (regAddr == REG_STAT);
  assign wrCmd = regWrite && (regAddr == REG_CMD);
  assign accClr = wrStat && regWrData[ST_ACCERR_BIT];

  // only the five documented codes are accepted
  assign validCmd = (regWrData == CMD_BLANK) || (regWrData == CMD_PAGE) ||
    (regWrData == CMD_MASS) || (regWrData == CMD_BYTE) ||
    (regWrData == CMD_BURST);

  // duration of one command in flash periods
  function automatic logic [TICK_W-1:0] ticksFor(input logic [7:0] cmd, input logic burst);
    logic [TICK_W-1:0] t;
    t = BLANK_TICKS;
    if (cmd == CMD_BYTE || cmd == CMD_BURST) begin
      t = burst ? BURST_TICKS : BYTE_TICKS;
    end else if (cmd == CMD_PAGE) begin
      t = PAGE_TICKS;
    end else if (cmd == CMD_MASS) begin
      t = TICK_W'(MASS_ERASE_TICKS);
    end
    return t;
  endfunction

  // flash timing clock: prescale then divide by div+1, idle until loaded
  assign preWrap = !pre8_q || (preCnt_q == PRE8_LAST);
  assign flashTick = divLoaded_q && preWrap && (divCnt_q == div_q);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      preCnt_q <= 3'h0;
      divCnt_q <= DIV_RESET;
    end else if (!divLoaded_q) begin
      preCnt_q <= 3'h0;
      divCnt_q <= DIV_RESET;
    end else begin
      preCnt_q <= (preWrap || !pre8_q) ? 3'h0 : preCnt_q + 3'h1;
      if (preWrap) begin
        divCnt_q <= (divCnt_q == div_q) ? DIV_RESET : divCnt_q + 6'h01;
      end
    end
  end

  // divider takes one write per reset, and none while an error stands
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      divLoaded_q <= 1'b0;
      pre8_q <= 1'b0;
      div_q <= DIV_RESET;
    end else if (wrDiv && !divLoaded_q && !accerr_q && seq_q == SEQ_IDLE) begin
      divLoaded_q <= 1'b1;
      pre8_q <= regWrData[DIV_PRE8_BIT];
      div_q <= regWrData[DIV_W-1:0];
    end
  end

  // stop while an operation runs kills it
  assign stopAbort = stopReq && busy_q;

  // command protocol; any departure before launch ends the sequence with an error
  always_comb begin
    seq_d = seq_q;
    accSet = 1'b0;
    launch = 1'b0;
    unique case (seq_q)
      SEQ_IDLE: begin
        if (arrayWrite && !accerr_q) begin
          if (!divLoaded_q) begin
            accSet = 1'b1;
          end else begin
            seq_d = SEQ_ADDR;
          end
        end
      end
      SEQ_ADDR: begin
        if (arrayWrite || wrDiv) begin
          accSet = 1'b1;
          seq_d = SEQ_IDLE;
        end else if (wrStat) begin
          accSet = 1'b1;
          seq_d = SEQ_IDLE;
        end else if (wrCmd) begin
          if (validCmd) begin
            seq_d = SEQ_CMD;
          end else begin
            accSet = 1'b1;
            seq_d = SEQ_IDLE;
          end
        end
      end
      SEQ_CMD: begin
        if (arrayWrite || wrDiv || wrCmd) begin
          accSet = 1'b1;
          seq_d = SEQ_IDLE;
        end else if (wrStat) begin
          if (regWrData[ST_CBEF_BIT]) begin
            launch = 1'b1;
            seq_d = SEQ_QUEUED;
          end else begin
            accSet = 1'b1;
            seq_d = SEQ_IDLE;
          end
        end
      end
      SEQ_QUEUED: begin
        if (arrayWrite) begin
          accSet = 1'b1;
        end
        if (take) begin
          seq_d = SEQ_IDLE;
        end
      end
    endcase
    if (stopAbort) begin
      accSet = 1'b1;
      seq_d = SEQ_IDLE;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      seq_q <= SEQ_IDLE;
    end else begin
      seq_q <= seq_d;
    end
  end

  // error flag: a new error wins over a same-cycle clear
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      accerr_q <= 1'b0;
    end else begin
      accerr_q <= accSet || (accerr_q && !accClr);
    end
  end

  // latch address, data and code of the pending command
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      latAddr_q <= '0;
      latData_q <= 8'h00;
      cmdBuf_q <= CMD_RESET;
    end else begin
      if (seq_q == SEQ_IDLE && seq_d == SEQ_ADDR) begin
        latAddr_q <= arrayAddr;
        latData_q <= arrayData;
      end
      if (seq_q == SEQ_ADDR && seq_d == SEQ_CMD) begin
        cmdBuf_q <= regWrData;
      end
    end
  end

  // execution: counted in flash ticks only
  assign execDone = busy_q && flashTick && (tickCnt_q == 15'd1);
  assign take = (seq_q == SEQ_QUEUED) && (!busy_q || execDone) && !stopReq;
  // shorter burst time for a sequential burst byte on the same row
  assign chain = execDone && (opCmd_q == CMD_BURST) && (cmdBuf_q == CMD_BURST) &&
    (latAddr_q == opAddr + 16'h0001) && (latAddr_q[ROW_BITS-1:0] != 6'h00);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      busy_q <= 1'b0;
      tickCnt_q <= '0;
      opCmd_q <= CMD_RESET;
      opAddr <= '0;
      opData <= 8'h00;
    end else if (stopAbort) begin
      busy_q <= 1'b0;
      tickCnt_q <= '0;
    end else if (take) begin
      busy_q <= 1'b1;
      tickCnt_q <= ticksFor(cmdBuf_q, chain);
      opCmd_q <= cmdBuf_q;
      if (cmdBuf_q == CMD_PAGE) begin
        opAddr <= {latAddr_q[ARR_ADDR_W-1:PAGE_BITS], 9'h000};
      end else begin
        opAddr <= latAddr_q;
      end
      // erase and blank check never use the latched data
      opData <= (cmdBuf_q == CMD_BYTE || cmdBuf_q == CMD_BURST) ? latData_q : 8'hff;
    end else if (execDone) begin
      busy_q <= 1'b0;
      tickCnt_q <= '0;
    end else if (busy_q && flashTick) begin
      tickCnt_q <= tickCnt_q - 15'd1;
    end
  end

  // array control outputs, registered
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pumpOn <= 1'b0;
      programActive <= 1'b0;
      eraseActive <= 1'b0;
      massErase <= 1'b0;
    end else begin
      pumpOn <= (busy_q && !execDone && !stopAbort && opCmd_q != CMD_BLANK) ||
        (take && cmdBuf_q != CMD_BLANK);
      programActive <= take ? (cmdBuf_q == CMD_BYTE || cmdBuf_q == CMD_BURST) :
        programActive && busy_q && !execDone && !stopAbort;
      eraseActive <= take ? (cmdBuf_q == CMD_PAGE || cmdBuf_q == CMD_MASS) :
        eraseActive && busy_q && !execDone && !stopAbort;
      massErase <= take ? (cmdBuf_q == CMD_MASS) :
        massErase && busy_q && !execDone && !stopAbort;
    end
  end

  // blank result sampled at the end of a blank check, cleared on launch
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      blank_q <= 1'b0;
    end else if (launch) begin
      blank_q <= 1'b0;
    end else if (execDone && opCmd_q == CMD_BLANK) begin
      blank_q <= arrayBlank;
    end
  end

  // complete: nothing running and nothing queued
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ccf_q <= 1'b1;
    end else if (launch) begin
      ccf_q <= 1'b0;
    end else begin
      ccf_q <= (seq_q != SEQ_QUEUED) && (!busy_q || execDone || stopAbort);
    end
  end

  // read data stand in the cycle after the strobe only
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      regRdData <= 8'h00;
    end else if (regRead) begin
      unique case (regAddr)
        REG_DIV: regRdData <= {divLoaded_q, pre8_q, div_q};
        REG_STAT: regRdData <= {seq_q != SEQ_QUEUED, ccf_q, 1'b0, accerr_q,
          1'b0, blank_q, 2'b00};
        REG_CMD: regRdData <= cmdBuf_q;
        default: regRdData <= 8'h00;
      endcase
    end else begin
      regRdData <= 8'h00;
    end
  end
endmodule
`default_nettype wire

// ==== fcs_pkg.sv ====
// package of constants for the flash command sequencer
`default_nettype none
package fcs_pkg;
  // register offsets on the plain register port
  localparam int ADDR_W = 2;
  localparam logic [1:0] REG_DIV = 2'h0;
  localparam logic [1:0] REG_STAT = 2'h1;
  localparam logic [1:0] REG_CMD = 2'h2;
  // divider register fields
  localparam int DIV_LOADED_BIT = 7;
  localparam int DIV_PRE8_BIT = 6;
  localparam int DIV_W = 6;
  localparam logic [5:0] DIV_RESET = 6'h00;
  // status register fields
  localparam int ST_CBEF_BIT = 7;
  localparam int ST_CCF_BIT = 6;
  localparam int ST_ACCERR_BIT = 4;
  localparam int ST_BLANK_BIT = 2;
  // command codes
  localparam logic [7:0] CMD_BLANK = 8'h05;
  localparam logic [7:0] CMD_BYTE = 8'h20;
  localparam logic [7:0] CMD_BURST = 8'h25;
  localparam logic [7:0] CMD_PAGE = 8'h40;
  localparam logic [7:0] CMD_MASS = 8'h41;
  localparam logic [7:0] CMD_RESET = 8'h00;
  // durations in flash timing clock periods
  localparam int TICK_W = 15;
  localparam logic [14:0] BYTE_TICKS = 15'd9;
  localparam logic [14:0] BURST_TICKS = 15'd4;
  localparam logic [14:0] PAGE_TICKS = 15'd4000;
  localparam logic [14:0] BLANK_TICKS = 15'd16;
  localparam int MASS_TICKS_DEFAULT = 20000;
  // prescaler used when the divide-by-eight bit is set
  localparam logic [2:0] PRE8_LAST = 3'h7;
  // array geometry
  localparam int ARR_ADDR_W = 16;
  localparam int PAGE_BITS = 9;
  localparam int ROW_BITS = 6;
  // command sequence states, Gray ordered along the usual path
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_ADDR = 2'b01,
    SEQ_CMD = 2'b11,
    SEQ_QUEUED = 2'b10
  } fcs_seq_type;
endpackage
`default_nettype wire

// ==== fcs_sva.sv ====
// port assertions for the flash command sequencer
`default_nettype none
module fcs_sva (
  input wire logic mclk,
  input wire logic reset,
  input wire logic regRead,
  input wire logic stopReq,
  input wire logic [7:0] regRdData,
  input wire logic pumpOn,
  input wire logic programActive,
  input wire logic eraseActive,
  input wire logic massErase,
  input wire logic [15:0] opAddr,
  input wire logic [7:0] opData,
  input wire logic flashTick
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // read data lives only in the cycle after the strobe
  property p_rd_idle; !$past(regRead) |-> regRdData == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
  property p_erase_data; eraseActive |-> opData == 8'hff; endproperty
  a_erase_data: assert property (p_erase_data) else $error("erase data used");
  // a page erase always works on a whole page
  property p_page_base; eraseActive && !massErase |-> opAddr[8:0] == 9'h000; endproperty
  a_page_base: assert property (p_page_base) else $error("page not aligned");
  property p_mass_sub; massErase |-> eraseActive; endproperty
  a_mass_sub: assert property (p_mass_sub) else $error("mass without erase");
  property p_one_op; programActive |-> !eraseActive; endproperty
  a_one_op: assert property (p_one_op) else $error("two ops at once");
  property p_pump; programActive || eraseActive |-> pumpOn; endproperty
  a_pump: assert property (p_pump) else $error("pulse without pump");
  // latched address must not drift mid-erase
  // a queued erase may take over only at the tick that ends the running one
  property p_erase_hold;
    eraseActive && $past(eraseActive) && !$past(flashTick) |-> $stable(opAddr);
  endproperty
  a_erase_hold: assert property (p_erase_hold) else $error("erase addr moved");
  property p_stop;
    stopReq && (programActive || eraseActive) |-> ##[1:3] !(programActive || eraseActive);
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not abort");
endmodule
bind fcs_flash_command_sequencer fcs_sva fcs_sva_inst (.mclk(mclk), .reset(reset),
  .regRead(regRead), .stopReq(stopReq), .regRdData(regRdData), .pumpOn(pumpOn),
  .programActive(programActive), .eraseActive(eraseActive), .massErase(massErase),
  .opAddr(opAddr), .opData(opData), .flashTick(flashTick));
`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench for the flash command sequencer
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import fcs_pkg::*;
  logic mclk = 1'b0, reset = 1'b1, stopReq = 1'b0, arrayBlank = 1'b0;
  logic regWrite, regRead, arrayWrite, pumpOn, programActive, eraseActive, massErase, flashTick;
  logic [1:0] regAddr;
  logic [7:0] regWrData, regRdData, arrayData, opData, st, lastData, d;
  logic [15:0] arrayAddr, opAddr, lastAddr, a;
  int n_mismatch = 0, checked = 0, nTick = 0, cyc = 0, t0 = 0;
  // codes outside the five valid ones
  logic [7:0] badCode [4] = '{8'h06, 8'h24, 8'h42, 8'hff};
  always #5 mclk = ~mclk;
  // short mass erase keeps the run brief
  fcs_flash_command_sequencer #(.MASS_ERASE_TICKS(50)) fcs_flash_command_sequencer_inst (
    .mclk(mclk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .arrayWrite(arrayWrite),
    .arrayAddr(arrayAddr), .arrayData(arrayData), .stopReq(stopReq), .arrayBlank(arrayBlank),
    .pumpOn(pumpOn), .programActive(programActive), .eraseActive(eraseActive),
    .massErase(massErase), .opAddr(opAddr), .opData(opData), .flashTick(flashTick));
  fcs_cpu fcs_cpu_inst (.mclk(mclk), .regRdData(regRdData), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .arrayWrite(arrayWrite),
    .arrayAddr(arrayAddr), .arrayData(arrayData));
  // ticks inside pulses, last program target, hang limit
  always @(posedge mclk) begin
    cyc++;
    if ((programActive || eraseActive) && flashTick) nTick++;
    if (programActive) {lastAddr, lastData} = {opAddr, opData};
    if (cyc == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end
  task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h got %h", name, exp, got);
    end
  endtask
  task automatic rdchk(input logic [1:0] r, input logic [7:0] exp);
    fcs_cpu_inst.rd(r, st);
    check("register", 16'(st), 16'(exp));
  endtask
  task automatic runCmd(input logic [15:0] ad, input logic [7:0] c, input int t);
    nTick = 0;
    fcs_cpu_inst.cmd(ad, d, c);
    repeat (3000) begin
      fcs_cpu_inst.rd(REG_STAT, st);
      if (st[ST_CCF_BIT] === 1'b1) break;
    end
    check("done", 16'(st[ST_CCF_BIT]), 16'd1);
    if (t >= 0) check("ticks", 16'(nTick), 16'(t));
  endtask
  task automatic complete_run;
    if (n_mismatch == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    void'($urandom(61));
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    rdchk(REG_STAT, 8'hc0);
    rdchk(2'h3, 8'h00);
    fcs_cpu_inst.arr(16'h1234, 8'h55);
    rdchk(REG_STAT, 8'hd0);
    fcs_cpu_inst.wr(REG_DIV, 8'h03);
    rdchk(REG_DIV, 8'h00);
    fcs_cpu_inst.wr(REG_STAT, 8'h10);
    rdchk(REG_STAT, 8'hc0);
    // fast divider first so the long erases fit the run
    fcs_cpu_inst.wr(REG_DIV, 8'h00);
    fcs_cpu_inst.wr(REG_DIV, 8'h05);
    rdchk(REG_DIV, 8'h80);
    // fresh pages only, never a byte programmed twice
    a = 16'($urandom);
    d = 8'($urandom);
    runCmd(a, CMD_BYTE, 9);
    check("addr", lastAddr, a);
    check("data", 16'(lastData), 16'(d));
    runCmd(16'($urandom), CMD_PAGE, 4000);
    runCmd(16'($urandom), CMD_MASS, 50);
    @(posedge mclk) arrayBlank <= 1'b1;
    runCmd(16'($urandom), CMD_BLANK, -1);
    rdchk(REG_STAT, 8'hc4);
    // second burst byte queued behind the first on the same row
    a = {a[15:6], 6'h01 + 6'($urandom % 60)};
    nTick = 0;
    fcs_cpu_inst.cmd(a, d, CMD_BURST);
    runCmd(a + 16'h1, CMD_BURST, -1);
    check("burst", 16'(nTick), 16'd13);
    foreach (badCode[i]) begin
      fcs_cpu_inst.arr(16'($urandom), d);
      fcs_cpu_inst.wr(REG_CMD, badCode[i]);
      rdchk(REG_STAT, 8'hd0);
      fcs_cpu_inst.wr(REG_STAT, 8'h10);
    end
    fcs_cpu_inst.arr(a, d);
    fcs_cpu_inst.wr(REG_CMD, CMD_BYTE);
    fcs_cpu_inst.wr(REG_STAT, 8'h00);
    rdchk(REG_STAT, 8'hd0);
    nTick = 0;
    fcs_cpu_inst.cmd(a, d, CMD_BYTE);
    repeat (20) @(posedge mclk);
    check("blocked", 16'(nTick), 16'd0);
    fcs_cpu_inst.wr(REG_STAT, 8'h10);
    fcs_cpu_inst.arr(a, d);
    fcs_cpu_inst.arr(a, d);
    rdchk(REG_STAT, 8'hd0);
    fcs_cpu_inst.wr(REG_STAT, 8'h10);
    fcs_cpu_inst.cmd(a, d, CMD_PAGE);
    repeat (30) @(posedge mclk);
    check("erasing", 16'(eraseActive), 16'd1);
    check("pump", 16'(pumpOn), 16'd1);
    stopReq <= 1'b1;
    @(posedge mclk) stopReq <= 1'b0;
    repeat (4) @(posedge mclk);
    check("erase", 16'(eraseActive), 16'd0);
    fcs_cpu_inst.rd(REG_STAT, st);
    check("accerr", 16'(st[ST_ACCERR_BIT]), 16'd1);
    // reset again, then a legal divider: 8 x 64 gives a tick every 512 cycles
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    fcs_cpu_inst.wr(REG_DIV, 8'h7f);
    rdchk(REG_DIV, 8'hff);
    t0 = cyc;
    runCmd(a ^ 16'h4000, CMD_BYTE, 9);
    check("slow", 16'(cyc - t0 > 8 * 512), 16'd1);
    complete_run();
  end
endmodule
`default_nettype wire
